// *** src/dpp_pkg.sv ***
// Constants for the dual phase-correct PWM block.
// Assumes a single 10 MHz clock domain and active-low async reset.
package dpp_pkg;
  localparam int CNT_W = 10;
  localparam logic [9:0] TOP_8 = 10'h0FF;
  localparam logic [9:0] TOP_9 = 10'h1FF;
  localparam logic [9:0] TOP_10 = 10'h3FF;
  localparam logic [9:0] ZERO_CNT = 10'h000;
  localparam logic [1:0] RES_8 = 2'h1;
  localparam logic [1:0] RES_9 = 2'h2;
  localparam logic [2:0] PS_STOP = 3'h0;
  localparam logic [2:0] PS_DIV1 = 3'h1;
  localparam logic [2:0] PS_DIV8 = 3'h2;
  localparam logic [2:0] PS_DIV64 = 3'h3;
  localparam logic [2:0] PS_DIV256 = 3'h4;
  localparam logic [2:0] PS_DIV1024 = 3'h5;
  localparam logic [9:0] DIV8_M1 = 10'h007;
  localparam logic [9:0] DIV64_M1 = 10'h03F;
  localparam logic [9:0] DIV256_M1 = 10'h0FF;
  localparam logic [9:0] DIV1024_M1 = 10'h3FF;
  typedef enum logic [1:0] {
    DPP_UP = 2'b01,
    DPP_DOWN = 2'b10
  } dpp_dir_t;
  typedef struct packed {
    logic [9:0] cnt;
    dpp_dir_t dir;
    logic [9:0] pre;
    logic [9:0] hold_a;
    logic [9:0] hold_b;
    logic [9:0] act_a;
    logic [9:0] act_b;
    logic out_a;
    logic out_b;
    logic pend_a;
    logic pend_b;
    logic pin_a;
    logic pin_b;
    logic ovf;
    logic cfa;
    logic cfb;
    logic irq_ovf;
    logic irq_a;
    logic irq_b;
  } dpp_state_t;
endpackage

// *** src/dpp_pwm.sv ***
// Dual-channel phase-correct PWM of a 16-bit timer (8/9/10-bit TOP).
// Assumes CPU strobes and mode bits synchronous to clock; no register bus.
// Overview of operation
// - Count up from zero to TOP, turn, count down to zero, repeat.
// - TOP is 255, 511 or 1023 by resolution; period is twice TOP.
// - Match when counter equals low ten bits of channel compare value.
// - Two independent channels A and B, each with own pin and mode bits.
// - Mode 1,0: clear on up-count match, set on down-count match.
// - Mode 1,1: clear on down-count match, set on up-count match.
// - Upper mode bit 0 disconnects the pin from the timer.
// - Undivided clock and compare equal TOP gives no pulse.
// - Divided clock and compare at TOP: up match at TOP, down match at next TOP.
// - Compare writes go to holding register, latched at TOP.
// - Reads return the holding register, the latest written value.
// - Compare zero, or TOP on undivided clock, drives pin high (mode 1,0) or low (mode 1,1) at next match.
// - Overflow flag sets when counter leaves zero.
// - Interrupt requests need flag, specific enable and global enable.
// - Compare flag sets the cycle after the compare event.
// - Prescale code zero stops the counter.
module dpp_pwm
  import dpp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [2:0] prescale_sel,
  input wire logic [1:0] resolution,
  input wire logic chan_a_mode_hi,
  input wire logic chan_a_mode_lo,
  input wire logic chan_b_mode_hi,
  input wire logic chan_b_mode_lo,
  input wire logic compare_value_a_we,
  input wire logic compare_value_b_we,
  input wire logic [15:0] compare_wdata,
  input wire logic ovf_clear,
  input wire logic cmp_a_clear,
  input wire logic cmp_b_clear,
  input wire logic ovf_ie,
  input wire logic cmp_a_ie,
  input wire logic cmp_b_ie,
  input wire logic global_ie,
  input wire logic port_pin_five,
  input wire logic port_pin_four,
  output logic [9:0] compare_value_a,
  output logic [9:0] compare_value_b,
  output logic [9:0] count,
  output logic count_down,
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic overflow_flag,
  output logic cmp_flag_a,
  output logic cmp_flag_b,
  output logic ovf_irq,
  output logic cmp_a_irq,
  output logic cmp_b_irq
);
  // ==========================================================
  // State
  dpp_state_t st;
  dpp_state_t next_st;
  logic [9:0] top;
  logic tick;
  logic [9:0] pre_max;
  logic up;
  logic at_top;
  logic [1:0] match;
  logic [1:0] mode_hi;
  logic [1:0] mode_lo;
  logic [1:0] out_cur;
  logic [1:0] pend_cur;
  logic [1:0] next_out;
  logic [1:0] next_pend;
  logic [1:0] pin_port;

  assign mode_hi = {chan_b_mode_hi, chan_a_mode_hi};
  assign mode_lo = {chan_b_mode_lo, chan_a_mode_lo};
  assign out_cur = {st.out_b, st.out_a};
  assign pend_cur = {st.pend_b, st.pend_a};
  assign pin_port = {port_pin_four, port_pin_five};

  // ==========================================================
  // Resolution and prescaler
  always_comb begin
    case (resolution)
      RES_8: top = TOP_8;
      RES_9: top = TOP_9;
      default: top = TOP_10;
    endcase
    case (prescale_sel)
      PS_DIV8: pre_max = DIV8_M1;
      PS_DIV64: pre_max = DIV64_M1;
      PS_DIV256: pre_max = DIV256_M1;
      PS_DIV1024: pre_max = DIV1024_M1;
      default: pre_max = ZERO_CNT;
    endcase
  end
  // Stop code holds the counter
  assign tick = (prescale_sel != PS_STOP) && (st.pre >= pre_max);
  assign up = (st.dir == DPP_UP);
  assign at_top = tick && (st.cnt == top);
  // Match on timer tick in either direction
  assign match[0] = tick && (st.cnt == st.act_a);
  assign match[1] = tick && (st.cnt == st.act_b);

  // ==========================================================
  // Per-channel output action
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      always_comb begin
        next_out[g] = out_cur[g];
        next_pend[g] = pend_cur[g];
        if (match[g] && at_top && (prescale_sel != PS_DIV1)) begin
          // Activate at TOP; the down match waits for next TOP
          if (pend_cur[g]) begin
            next_out[g] = ~mode_lo[g];
            next_pend[g] = 1'b0;
          end else begin
            next_out[g] = mode_lo[g];
            next_pend[g] = 1'b1;
          end
        end else if (match[g] && at_top) begin
          // Up and down matches coincide: no pulse
          next_out[g] = ~mode_lo[g];
        end else if (match[g]) begin
          // Non-inverted / inverted actions
          next_out[g] = up ? mode_lo[g] : ~mode_lo[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.pre = tick ? ZERO_CNT : st.pre + 10'h001;
    if (prescale_sel == PS_STOP) begin
      next_st.pre = ZERO_CNT;
    end
    if (tick) begin
      // Up/down sweep
      if (up) begin
        if (st.cnt >= top) begin
          next_st.dir = DPP_DOWN;
          next_st.cnt = st.cnt - 10'h001;
        end else begin
          next_st.cnt = st.cnt + 10'h001;
        end
      end else begin
        if (st.cnt == ZERO_CNT) begin
          next_st.dir = DPP_UP;
          next_st.cnt = st.cnt + 10'h001;
        end else begin
          next_st.cnt = st.cnt - 10'h001;
        end
      end
    end
    // Double buffering of compare values
    if (compare_value_a_we) begin
      next_st.hold_a = compare_wdata[9:0];
    end
    if (compare_value_b_we) begin
      next_st.hold_b = compare_wdata[9:0];
    end
    if (at_top) begin
      next_st.act_a = st.hold_a;
      next_st.act_b = st.hold_b;
    end
    next_st.out_a = next_out[0];
    next_st.out_b = next_out[1];
    next_st.pend_a = next_pend[0];
    next_st.pend_b = next_pend[1];
    // Pin disconnected falls back to the port latch
    next_st.pin_a = mode_hi[0] ? next_out[0] : pin_port[0];
    next_st.pin_b = mode_hi[1] ? next_out[1] : pin_port[1];
    // Flags: set beats clear
    next_st.ovf = (tick && st.cnt == ZERO_CNT) || (st.ovf && !ovf_clear);
    next_st.cfa = match[0] || (st.cfa && !cmp_a_clear);
    next_st.cfb = match[1] || (st.cfb && !cmp_b_clear);
    // Interrupt gating
    next_st.irq_ovf = next_st.ovf && ovf_ie && global_ie;
    next_st.irq_a = next_st.cfa && cmp_a_ie && global_ie;
    next_st.irq_b = next_st.cfb && cmp_b_ie && global_ie;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '{dir: DPP_UP, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Readback of the holding register
  assign compare_value_a = st.hold_a;
  assign compare_value_b = st.hold_b;
  assign count = st.cnt;
  // Down bit of the one-hot direction flop
  assign count_down = st.dir[1];
  assign pwm_out_a = st.pin_a;
  assign pwm_out_b = st.pin_b;
  assign overflow_flag = st.ovf;
  assign cmp_flag_a = st.cfa;
  assign cmp_flag_b = st.cfb;
  assign ovf_irq = st.irq_ovf;
  assign cmp_a_irq = st.irq_a;
  assign cmp_b_irq = st.irq_b;

  // ==========================================================
  // Checks
  a_cnt_bound: assert property (@(posedge clock) disable iff (!nrst)
    st.cnt <= top || $changed(resolution) || $past(resolution) != resolution)
    else $error("counter above TOP");
  a_stop_hold: assert property (@(posedge clock) disable iff (!nrst)
    (prescale_sel == PS_STOP) |=> $stable(st.cnt))
    else $error("counter moved while stopped");
  a_ovf_set: assert property (@(posedge clock) disable iff (!nrst)
    (tick && st.cnt == ZERO_CNT) |=> overflow_flag)
    else $error("overflow flag not set leaving zero");
  a_cmp_flag: assert property (@(posedge clock) disable iff (!nrst)
    match[0] |=> cmp_flag_a)
    else $error("compare flag A not set after match");
  a_latch_top: assert property (@(posedge clock) disable iff (!nrst)
    !at_top && !($past(at_top)) |=> $stable(st.act_a) || $past(at_top))
    else $error("active compare changed away from TOP");
  a_read_back: assert property (@(posedge clock) disable iff (!nrst)
    compare_value_b_we |=> compare_value_b == $past(compare_wdata[9:0]))
    else $error("read back not latest write");
  a_irq_gate: assert property (@(posedge clock) disable iff (!nrst)
    ovf_irq |-> overflow_flag && $past(global_ie) && $past(ovf_ie))
    else $error("overflow request without enables");
  a_disc_pin: assert property (@(posedge clock) disable iff (!nrst)
    !chan_a_mode_hi |=> pwm_out_a == $past(port_pin_five))
    else $error("disconnected pin followed timer");
  a_noninv_up: assert property (@(posedge clock) disable iff (!nrst)
    (match[0] && up && !at_top && chan_a_mode_hi && !chan_a_mode_lo) |=> !pwm_out_a)
    else $error("non-inverted up match did not clear");
  a_turn_top: assert property (@(posedge clock) disable iff (!nrst)
    (tick && up && st.cnt == top) |=> count_down)
    else $error("no turn at TOP");
endmodule

// *** verif/dpp_load.sv ***
// Load model on the two PWM pins: counts high cycles per window.
// Assumes pins change on the block clock; clr restarts both counts.
module dpp_load (
  input wire logic clock,
  input wire logic clr,
  input wire logic pwm_a,
  input wire logic pwm_b,
  output logic [11:0] high_a,
  output logic [11:0] high_b
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clock) begin
    high_a <= clr ? 12'h000 : high_a + {11'h000, pwm_a};
    high_b <= clr ? 12'h000 : high_b + {11'h000, pwm_b};
  end
endmodule

// *** verif/dpp_pwm_bench.sv ***
// Bench for dpp_pwm: directed and LFSR stimulus, queue scoreboard.
// Assumes dpp_pkg and dpp_load are compiled before it.
module dpp_pwm_bench
  import dpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int sel; logic [11:0] exp;} dpp_note_t;
  logic clock, nrst, chan_a_mode_hi, chan_a_mode_lo, chan_b_mode_hi, chan_b_mode_lo;
  logic compare_value_a_we, compare_value_b_we, ovf_clear, cmp_a_clear, cmp_b_clear;
  logic ovf_ie, cmp_a_ie, cmp_b_ie, global_ie, port_pin_five, port_pin_four;
  logic pwm_out_a, pwm_out_b, overflow_flag, cmp_flag_a, cmp_flag_b, count_down;
  logic ovf_irq, cmp_a_irq, cmp_b_irq, load_clr;
  logic [2:0] prescale_sel;
  logic [1:0] resolution;
  logic [15:0] compare_wdata;
  logic [9:0] compare_value_a, compare_value_b, count;
  logic [11:0] high_a, high_b, meas;
  logic [31:0] seed;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  dpp_note_t notes[$];
  dpp_note_t n;
  dpp_pwm dpp_pwm_i (.clock, .nrst, .prescale_sel, .resolution, .chan_a_mode_hi,
    .chan_a_mode_lo, .chan_b_mode_hi, .chan_b_mode_lo, .compare_value_a_we,
    .compare_value_b_we, .compare_wdata, .ovf_clear, .cmp_a_clear, .cmp_b_clear, .ovf_ie,
    .cmp_a_ie, .cmp_b_ie, .global_ie, .port_pin_five, .port_pin_four, .compare_value_a,
    .compare_value_b, .count, .count_down, .pwm_out_a, .pwm_out_b, .overflow_flag,
    .cmp_flag_a, .cmp_flag_b, .ovf_irq, .cmp_a_irq, .cmp_b_irq);
  dpp_load dpp_load_i (.clock, .clr(load_clr), .pwm_a(pwm_out_a), .pwm_b(pwm_out_b),
    .high_a, .high_b);
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  // ==========================================
  // Scoreboard
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] got(input int s);
    case (s)
      0: return {2'h0, compare_value_a};
      1: return {2'h0, compare_value_b};
      2: return {2'h0, count};
      3: return {11'h000, pwm_out_a};
      4: return {11'h000, pwm_out_b};
      5: return {11'h000, overflow_flag};
      6: return {11'h000, ovf_irq};
      7: return meas;
      8: return high_a;
      9: return high_b;
      11: return {11'h000, cmp_flag_b};
      12: return {11'h000, cmp_a_irq};
      13: return {11'h000, cmp_b_irq};
      14: return {11'h000, count_down};
      default: return {11'h000, cmp_flag_a};
    endcase
  endfunction
  task automatic cmp_val(input logic [11:0] g, input logic [11:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  always @(negedge clock) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      cmp_val(got(n.sel), n.exp);
    end
  end
  task automatic note(input int s, input logic [11:0] e);
    notes.push_back('{s, e});
  endtask
  task automatic final_report();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      final_report();
    end
  end
  // ==========================================
  // Drivers and tests
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #10;
  endtask
  task automatic wait_cnt(input logic [9:0] v);
    for (int i = 0; i < 5000 && count !== v; i++) tick(1);
  endtask
  task automatic period(input logic [1:0] r, input logic [9:0] t);
    wait_cnt(ZERO_CNT);
    resolution = r;
    tick(1);
    meas = 12'h001;
    while (count !== ZERO_CNT && meas < 12'hBB8) begin
      tick(1);
      meas++;
    end
    note(7, {1'b0, t, 1'b0});
    note(14, 12'h001);
    $display("test period done");
  endtask
  task automatic duty(input logic [9:0] ca, input logic [9:0] cb);
    compare_wdata = {seed[31:26], ca};
    compare_value_a_we = 1;
    tick(1);
    compare_wdata = {seed[25:20], cb};
    compare_value_a_we = 0;
    compare_value_b_we = 1;
    tick(1);
    compare_value_b_we = 0;
    note(0, {2'h0, ca});
    note(1, {2'h0, cb});
    tick(1100);
    load_clr = 1;
    tick(1);
    load_clr = 0;
    tick(510);
    note(8, {1'b0, ca, 1'b0});
    note(9, 12'h1FE - {1'b0, cb, 1'b0});
    wait_cnt(ca);
    tick(1);
    note(10, 12'h001);
    note(11, 12'h001);
    note(12, 12'h001);
    note(13, 12'h000);
    cmp_a_clear = 1;
    tick(1);
    cmp_a_clear = 0;
    note(10, 12'h000);
    note(12, 12'h000);
    $display("test duty done");
  endtask
  task automatic ovf_test(input logic g);
    ovf_ie = 1;
    global_ie = g;
    ovf_clear = 1;
    tick(1);
    ovf_clear = 0;
    wait_cnt(ZERO_CNT);
    tick(1);
    note(5, 12'h001);
    note(2, 12'h001);
    note(14, 12'h000);
    tick(1);
    note(6, {11'h000, g});
    ovf_clear = 1;
    tick(1);
    ovf_clear = 0;
    note(5, 12'h000);
    note(6, 12'h000);
    $display("test overflow done");
  endtask
  // Compare A at TOP, compare B at zero; window spans a whole pin cycle
  task automatic top_case(input logic [2:0] ps, input logic [11:0] ea, input int win);
    prescale_sel = ps;
    wait_cnt(TOP_8);
    tick(10);
    wait_cnt(TOP_8);
    tick(10);
    cmp_b_clear = 1;
    load_clr = 1;
    tick(1);
    cmp_b_clear = 0;
    load_clr = 0;
    note(11, 12'h000);
    tick(win);
    note(8, ea);
    note(9, 12'h000);
    $display("test top compare done");
  endtask
  initial begin
    {compare_value_a_we, compare_value_b_we, compare_wdata, ovf_clear, cmp_a_clear} = '0;
    {cmp_b_clear, ovf_ie, cmp_a_ie, cmp_b_ie, global_ie, port_pin_five, port_pin_four} = '0;
    {prescale_sel, resolution, chan_a_mode_hi, chan_a_mode_lo, chan_b_mode_hi} = '0;
    {chan_b_mode_lo, load_clr, nrst} = '0;
    seed = 32'h7B8E1162;
    tick(16);
    nrst = 1;
    prescale_sel = PS_DIV1;
    period(RES_8, TOP_8);
    period(RES_9, TOP_9);
    period(2'h3, TOP_10);
    period(RES_8, TOP_8);
    chan_a_mode_hi = 1;
    chan_b_mode_hi = 1;
    chan_b_mode_lo = 1;
    cmp_a_ie = 1;
    global_ie = 1;
    repeat (2) begin
      seed = lfsr(seed);
      duty({2'h0, seed[6:0]} + 10'h040, {2'h0, seed[14:8]} + 10'h040);
    end
    chan_a_mode_hi = 0;
    chan_b_mode_hi = 0;
    for (int i = 0; i < 4; i++) begin
      chan_a_mode_lo = i[0];
      chan_b_mode_lo = i[1];
      port_pin_five = i[1];
      port_pin_four = ~i[0];
      tick(2);
      note(3, {11'h000, port_pin_five});
      note(4, {11'h000, port_pin_four});
    end
    $display("test disconnect done");
    ovf_test(1);
    ovf_test(0);
    chan_a_mode_hi = 1;
    chan_a_mode_lo = 0;
    chan_b_mode_hi = 1;
    chan_b_mode_lo = 1;
    compare_wdata = {6'h00, TOP_8};
    compare_value_a_we = 1;
    tick(1);
    compare_wdata = 16'h0000;
    compare_value_a_we = 0;
    compare_value_b_we = 1;
    tick(1);
    compare_value_b_we = 0;
    top_case(PS_DIV1, 12'h1FE, 510);
    top_case(PS_DIV8, 12'hFF0, 8160);
    prescale_sel = PS_STOP;
    tick(1);
    meas = {2'h0, count};
    tick(20);
    note(2, meas);
    $display("test stop done");
    tick(1);
    final_report();
  end
endmodule
